// ### hw/rxd_defines.svh
// Purpose: constants for the expansion card decode and nonvolatile control
// Assumes: 20-bit memory addresses, 16-bit I/O port addresses
// Notes:   shared by the decode module and the assertion module
`ifndef RXD_DEFINES_SVH
`define RXD_DEFINES_SVH

`define RXD_MEM_AW        20
`define RXD_IO_AW         16
`define RXD_DW            16
// read-only window bases for the four strap settings
`define RXD_BASE_64K      20'hf0000
`define RXD_BASE_128K     20'he0000
`define RXD_BASE_256K     20'hc0000
`define RXD_BASE_512K     20'hb0000
// nonvolatile ram port window and store port
`define RXD_NV_LO         16'h0200
`define RXD_NV_HI         16'h03fe
`define RXD_STORE_PORT    16'h00e0
`define RXD_NV_DEPTH      256
// socket count and socket pair count
`define RXD_SOCKETS       8
`define RXD_PAIRS         4
// store and recall pulse lengths as seen by the nonvolatile parts
`define RXD_STORE_NS      100
`define RXD_RECALL_NS     100
`define RXD_CLK_NS        8
`define RXD_STORE_CYC     ((`RXD_STORE_NS + `RXD_CLK_NS - 1) / `RXD_CLK_NS)
`define RXD_RECALL_CYC    ((`RXD_RECALL_NS + `RXD_CLK_NS - 1) / `RXD_CLK_NS)

`endif

// ### hw/rxd_pkg.sv
// Purpose: types for the expansion card decode
// Assumes: constants come from rxd_defines.svh
// Notes:   strap encoding follows the size order 64K, 128K, 256K, 512K
package rxd_pkg;
  typedef enum logic [1:0] {
    RXD_SZ_64K  = 2'h0,
    RXD_SZ_128K = 2'h1,
    RXD_SZ_256K = 2'h2,
    RXD_SZ_512K = 2'h3
  } rxd_size_t;

  // idle -> store or recall pulse -> idle; recall differs from idle in two bits
  typedef enum logic [1:0] {
    RXD_NV_IDLE   = 2'h0,
    RXD_NV_STORE  = 2'h1,
    RXD_NV_RECALL = 2'h3
  } rxd_nvst_t;
endpackage

// ### hw/rxd_expansion_decode.sv
// Purpose: decode and control for a read-only expansion card with nonvolatile ram
// Assumes: host bus cycles are synchronous to clk; one strobe cycle per access
// Notes:   the nonvolatile ram itself is modelled as an array; the eeprom shadow
//          is a second array so store and recall act on real contents
// Notes on behaviour
// - two byte sockets form one 16-bit word; both lanes read together.
// - size straps pick 64K, 128K, 256K or 320K bytes of claimed space.
// - window ends at FFFFF, starts F0000, E0000, C0000 or B0000 per strap.
// - extra chip selects drive a stacked second bank, up to 320K bytes in all.
// - read-only array answers only local bus cycles, never backplane requests.
// - nonvolatile ram is two 256 x 4 parts giving 256 bytes of 8 bits.
// - nonvolatile ram sits in I/O space at ports 200H to 3FEH, read and write.
// - ram reads and writes are plain single-cycle static accesses.
// - any write to I/O port 0E0H while idle issues a store, whatever the data.
// - store copies all ram contents into the eeprom, replacing old data.
// - at power-up eeprom contents are recalled into the ram.
// - with the recall strap fitted, every host reset also recalls.
`timescale 1ns/10ps
`include "rxd_defines.svh"

module rxd_expansion_decode #(
  parameter int STORE_CYC  = `RXD_STORE_CYC,
  parameter int RECALL_CYC = `RXD_RECALL_CYC
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      powerOn,
  // straps
  input  wire rxd_pkg::rxd_size_t        sizeStrap,
  input  wire logic                      stackedStrap,
  input  wire logic                      recallOnReset,
  // host local bus
  input  wire logic [`RXD_MEM_AW-1:0]    addr,
  input  wire logic                      memRead,
  input  wire logic                      ioRead,
  input  wire logic                      ioWrite,
  input  wire logic                      localCycle,
  input  wire logic [`RXD_DW-1:0]        dataIn,
  output logic      [`RXD_DW-1:0]        dataOut,
  output logic                           dataOe,
  // socket side
  output logic      [`RXD_SOCKETS/2-1:0] pairSelect,
  output logic      [`RXD_SOCKETS/2-1:0] stackSelect,
  output logic      [14:0]               partAddr,
  input  wire logic [`RXD_DW-1:0]        romData,
  // nonvolatile status
  output logic                           nvBusy
);
  import rxd_pkg::*;

  // a zero-length pulse would wrap the counter to FFFFH and run 65536 cycles, so refuse it at elaboration
  generate
    if (STORE_CYC < 1 || RECALL_CYC < 1) begin : gBadLen
      $error("store and recall lengths must be at least one cycle");
    end
  endgenerate

  logic [19:0]        winBase;
  logic               romHit;
  logic [18:0]        winOff;
  logic [1:0]         pairIdx;
  logic               stackBit;
  logic [15:0]        ioAddr;
  logic               nvHit;
  logic               storeHit;
  logic [7:0]         nvIdx;
  logic [7:0]         ramArr [`RXD_NV_DEPTH];
  logic [7:0]         eeArr  [`RXD_NV_DEPTH];
  rxd_nvst_t          nvState_ff;
  rxd_nvst_t          nxt_nvState;
  logic [15:0]        nvCnt_ff;
  logic [15:0]        nxt_nvCnt;
  logic [`RXD_DW-1:0] dataOut_ff;
  logic               dataOe_ff;
  logic               powerSeen_ff;

  // window base per strap setting
  always_comb begin
    case (sizeStrap)
      RXD_SZ_64K:  winBase = `RXD_BASE_64K;
      RXD_SZ_128K: winBase = `RXD_BASE_128K;
      RXD_SZ_256K: winBase = `RXD_BASE_256K;
      RXD_SZ_512K: winBase = `RXD_BASE_512K;
      default:     winBase = `RXD_BASE_64K;
    endcase
  end

  // only cycles from the local processor reach the sockets
  assign romHit = memRead && localCycle && (addr >= winBase);
  assign winOff = 19'(addr - winBase);

  // word offset bit 0 picks byte lanes, so part address starts at bit 1;
  // pair and stack bits sit just above the part address
  always_comb begin
    pairIdx  = 2'h0;
    stackBit = 1'b0;
    partAddr = 15'(winOff[15:1]);
    case (sizeStrap)
      RXD_SZ_64K: begin
        partAddr = {2'h0, winOff[13:1]};
        pairIdx  = winOff[15:14];
      end
      RXD_SZ_128K: begin
        // stacked small parts: two 64K banks; otherwise one bank of larger parts
        if (stackedStrap) begin
          partAddr = {2'h0, winOff[13:1]};
          pairIdx  = winOff[15:14];
          stackBit = winOff[16];
        end else begin
          partAddr = {1'b0, winOff[14:1]};
          pairIdx  = winOff[16:15];
        end
      end
      RXD_SZ_256K: begin
        partAddr = winOff[15:1];
        pairIdx  = winOff[17:16];
      end
      RXD_SZ_512K: begin
        partAddr = winOff[15:1];
        pairIdx  = winOff[17:16];
        stackBit = winOff[18];
      end
      default: begin
        partAddr = 15'h0000;
      end
    endcase
  end

  // one select per socket pair; both sockets of a pair are driven at once
  genvar g;
  generate
    for (g = 0; g < `RXD_PAIRS; g++) begin : gPair
      assign pairSelect[g]  = romHit && !stackBit && (pairIdx == 2'(g));
      assign stackSelect[g] = romHit && stackBit && (pairIdx == 2'(g));
    end
  endgenerate

  // I/O decode: even ports only in the ram window, store port exact
  assign ioAddr   = addr[15:0];
  assign nvHit    = (ioAddr >= `RXD_NV_LO) && (ioAddr <= `RXD_NV_HI) && !ioAddr[0];
  assign storeHit = (ioAddr == `RXD_STORE_PORT);
  assign nvIdx    = ioAddr[8:1];

  // store and recall sequencer; host ram accesses are refused while busy
  always_comb begin
    nxt_nvState = nvState_ff;
    nxt_nvCnt   = nvCnt_ff;
    case (nvState_ff)
      RXD_NV_IDLE: begin
        if (ioWrite && storeHit) begin
          nxt_nvState = RXD_NV_STORE;
          nxt_nvCnt   = 16'(STORE_CYC - 1);
        end
      end
      RXD_NV_STORE, RXD_NV_RECALL: begin
        if (nvCnt_ff == 16'h0000)
          nxt_nvState = RXD_NV_IDLE;
        else
          nxt_nvCnt = 16'(nvCnt_ff - 16'h0001);
      end
      default: nxt_nvState = RXD_NV_IDLE;
    endcase
  end

  // reset enters recall on power-up, or on any reset when strapped
  always_ff @(posedge clk) begin
    if (reset) begin
      if (!powerSeen_ff || recallOnReset) begin
        nvState_ff <= RXD_NV_RECALL;
        nvCnt_ff   <= 16'(RECALL_CYC - 1);
      end else begin
        nvState_ff <= RXD_NV_IDLE;
        nvCnt_ff   <= 16'h0000;
      end
    end else begin
      nvState_ff <= nxt_nvState;
      nvCnt_ff   <= nxt_nvCnt;
    end
  end

  // power flag survives host reset; cleared only by powerOn
  always_ff @(posedge clk) begin
    if (powerOn)
      powerSeen_ff <= 1'b0;
    else if (reset)
      powerSeen_ff <= 1'b1;
  end

  // whole-array copies happen in the last cycle of each pulse
  always_ff @(posedge clk) begin
    for (int i = 0; i < `RXD_NV_DEPTH; i++) begin
      if (nvState_ff == RXD_NV_STORE && nvCnt_ff == 16'h0000)
        eeArr[i] <= ramArr[i];
      else if (nvState_ff == RXD_NV_RECALL && nvCnt_ff == 16'h0000)
        ramArr[i] <= eeArr[i];
      else if (nvState_ff == RXD_NV_IDLE && ioWrite && nvHit && nvIdx == 8'(i))
        ramArr[i] <= dataIn[7:0];
    end
  end

  // read data: rom word on both lanes, ram byte on the low lane only
  always_ff @(posedge clk) begin
    if (reset) begin
      dataOut_ff <= 16'h0000;
      dataOe_ff  <= 1'b0;
    end else if (romHit) begin
      dataOut_ff <= romData;
      dataOe_ff  <= 1'b1;
    end else if (ioRead && nvHit && nvState_ff == RXD_NV_IDLE) begin
      dataOut_ff <= {8'h00, ramArr[nvIdx]};
      dataOe_ff  <= 1'b1;
    end else begin
      dataOe_ff  <= 1'b0;
    end
  end

  assign dataOut = dataOut_ff;
  assign dataOe  = dataOe_ff;
  assign nvBusy  = (nvState_ff != RXD_NV_IDLE);
endmodule

// ### verification/rxd_decode_asserts.sv
// Purpose: port checks for the expansion decode
// Assumes: registered answer one cycle after the taking edge
// Notes:   busy run bound covers store and recall alike
`timescale 1ns/10ps
`include "rxd_defines.svh"
module rxd_decode_asserts #(
  parameter int STORE_CYC  = 1,
  parameter int RECALL_CYC = 1
) (
  // clock, reset and straps
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               powerOn,
  input wire rxd_pkg::rxd_size_t sizeStrap,
  input wire logic               stackedStrap,
  input wire logic               recallOnReset,
  // host bus
  input wire logic [19:0]        addr,
  input wire logic               memRead,
  input wire logic               ioRead,
  input wire logic               ioWrite,
  input wire logic               localCycle,
  input wire logic [15:0]        dataIn,
  input wire logic [15:0]        dataOut,
  input wire logic               dataOe,
  // sockets and status
  input wire logic [3:0]         pairSelect,
  input wire logic [3:0]         stackSelect,
  input wire logic [14:0]        partAddr,
  input wire logic [15:0]        romData,
  input wire logic               nvBusy
);
  import rxd_pkg::*;
  localparam int MAXB = STORE_CYC + RECALL_CYC + 2;
  logic [19:0] base;
  logic [7:0]  busyCnt;
  wire rd    = memRead && !ioRead && !ioWrite;
  wire ioHit = addr[15:0] >= 16'h0200 && addr[15:0] <= 16'h03fe && !addr[0];
  // window start per strap
  always_comb begin
    case (sizeStrap)
      RXD_SZ_64K:  base = 20'hf0000;
      RXD_SZ_128K: base = 20'he0000;
      RXD_SZ_256K: base = 20'hc0000;
      default:     base = 20'hb0000;
    endcase
  end
  // busy run length; a stuck sequencer shows up here
  always_ff @(posedge clk) begin
    if (reset || !nvBusy) busyCnt <= 8'h00;
    else busyCnt <= busyCnt + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rom_local_only: assert property (rd && !localCycle |=> !dataOe)
    else $error("backplane cycle drove the bus");
  a_rom_below_base: assert property (rd && addr < base |=> !dataOe)
    else $error("read below window drove the bus");
  a_rom_word_read: assert property (rd && localCycle && addr >= base
    |=> dataOe && dataOut == $past(romData)) else $error("rom word not returned");
  a_store_start: assert property (ioWrite && addr[15:0] == 16'h00e0 && !nvBusy
    |=> nvBusy) else $error("store not started");
  a_busy_bounded: assert property (busyCnt <= MAXB)
    else $error("busy run too long");
  a_odd_port_quiet: assert property (ioRead && addr[0] |=> !dataOe)
    else $error("odd port drove the bus");
  a_store_rd_quiet: assert property (ioRead && addr[15:0] == 16'h00e0 |=> !dataOe)
    else $error("store port read drove the bus");
  a_ram_read_lane: assert property (ioRead && ioHit && !nvBusy && !memRead
    |=> dataOe && dataOut[15:8] == 8'h00) else $error("ram read lane wrong");
  a_busy_no_drive: assert property (ioRead && nvBusy |=> !dataOe)
    else $error("ram drove while busy");
  a_reset_recall: assert property ($fell(reset) && recallOnReset |-> ##[0:1] nvBusy)
    else $error("no recall after reset");
  a_sel_one_hot: assert property ($onehot0({pairSelect, stackSelect}))
    else $error("more than one socket pair selected");
  a_sel_local_only: assert property (!localCycle |-> {pairSelect, stackSelect} == 8'h00)
    else $error("backplane cycle selected a socket");
endmodule
bind rxd_expansion_decode rxd_decode_asserts #(.STORE_CYC(STORE_CYC),
  .RECALL_CYC(RECALL_CYC)) u_chk (.clk(clk), .reset(reset), .powerOn(powerOn),
  .sizeStrap(sizeStrap), .stackedStrap(stackedStrap), .recallOnReset(recallOnReset),
  .addr(addr), .memRead(memRead), .ioRead(ioRead), .ioWrite(ioWrite),
  .localCycle(localCycle), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
  .pairSelect(pairSelect), .stackSelect(stackSelect), .partAddr(partAddr),
  .romData(romData), .nvBusy(nvBusy));

// ### verification/rxd_rom_model.sv
// Purpose: socket pairs answering the decode
// Assumes: chip selects active high
// Notes:   one word for every pair, so a wrong select still reads back
`timescale 1ns/10ps
module rxd_rom_model (
  // clock and selects
  input  wire logic        clk,
  input  wire logic [3:0]  pairSelect,
  input  wire logic [3:0]  stackSelect,
  // word lanes
  output logic      [15:0] romData
);
  logic tgl = 1'b0;
  always @(posedge clk) tgl <= ~tgl;
  // released lanes alternate 3c5a and c3a5 each cycle, so every other cycle they match the selected word
  assign romData = |{pairSelect, stackSelect} ? 16'hc3a5 : (16'h3c5a ^ {16{tgl}});
endmodule

// ### verification/test_eprom_novram_expansion_decode.sv
// Purpose: bus-cycle tests of the expansion decode
// Assumes: short store and recall runs
// Notes:   stacked strap is tried once in the 128K setting
`timescale 1ns/10ps
module test_eprom_novram_expansion_decode;
  import rxd_pkg::*;
  logic clk = 0, reset = 1, powerOn = 1, recallOnReset = 0, stackedStrap = 0;
  logic memRead = 0, ioRead = 0, ioWrite = 0, localCycle = 0, dataOe, nvBusy;
  logic [19:0] addr = 0;
  logic [15:0] dataIn = 0, dataOut, romData;
  logic [3:0]  pairSelect, stackSelect;
  logic [14:0] partAddr, partSeen;
  logic [7:0]  selSeen;
  logic [7:0]  topSel [4] = '{8'h08, 8'h08, 8'h08, 8'h10};
  logic [14:0] topPart [4] = '{15'h1fff, 15'h3fff, 15'h7fff, 15'h7fff};
  rxd_size_t   sizeStrap = RXD_SZ_64K;
  logic [19:0] bases [4] = '{20'hf0000, 20'he0000, 20'hc0000, 20'hb0000};
  int n_mismatch = 0, checks = 0;
  always #4 clk = ~clk;
  rxd_expansion_decode #(.STORE_CYC(3), .RECALL_CYC(3)) u_dut (.clk(clk), .reset(reset),
    .powerOn(powerOn), .sizeStrap(sizeStrap), .stackedStrap(stackedStrap),
    .recallOnReset(recallOnReset), .addr(addr), .memRead(memRead), .ioRead(ioRead),
    .ioWrite(ioWrite), .localCycle(localCycle), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .pairSelect(pairSelect), .stackSelect(stackSelect), .partAddr(partAddr),
    .romData(romData), .nvBusy(nvBusy));
  rxd_rom_model u_rom (.clk(clk), .pairSelect(pairSelect), .stackSelect(stackSelect),
    .romData(romData));
  task print_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic eoe, input logic [15:0] ed);
    checks++;
    if (dataOe !== eoe || (eoe && dataOut !== ed)) begin
      n_mismatch++;
      $display("wrong value at %0t: read data %h", $time, dataOut);
    end
  endtask
  // selects and part address as seen during the strobe cycle
  task chkSel(input logic [7:0] es, input logic [14:0] ep);
    checks++;
    if (selSeen !== es || (es != 8'h00 && partSeen !== ep)) begin
      n_mismatch++;
      $display("wrong value at %0t: selects %h part %h", $time, selSeen, partSeen);
    end
  endtask
  task chkBusy(input logic e);
    checks++;
    if (nvBusy !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: busy flag", $time);
    end
  endtask
  // one strobe cycle; k is {memRead, ioRead, ioWrite, localCycle}
  task acc(input logic [3:0] k, input logic [19:0] a, input logic [15:0] d);
    @(posedge clk);
    {memRead, ioRead, ioWrite, localCycle} <= k;
    addr <= a;
    dataIn <= d;
    #1;
    selSeen = {stackSelect, pairSelect};
    partSeen = partAddr;
    @(posedge clk);
    {memRead, ioRead, ioWrite} <= 3'b000;
    #1;
  endtask
  task waitIdle;
    int i;
    for (i = 0; i < 200 && nvBusy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 200) begin
      n_mismatch++;
      $display("wrong value at %0t: busy never ended", $time);
      print_verdict;
    end
  endtask
  task rst(input logic p, input logic r);
    @(posedge clk);
    reset <= 1;
    powerOn <= p;
    recallOnReset <= r;
    repeat (3) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    powerOn <= 0;
    #1;
    chkBusy(p | r);
    waitIdle;
  endtask
  initial begin
    rst(1, 0);
    acc(4'b0010, 20'h00200, 16'h005a);
    acc(4'b0010, 20'h003fe, 16'h00a5);
    acc(4'b0010, 20'h00202, 16'h0033);
    acc(4'b0100, 20'h00200, 0); chk(1, 16'h005a);
    acc(4'b0100, 20'h003fe, 0); chk(1, 16'h00a5);
    acc(4'b0100, 20'h00201, 0); chk(0, 0);
    acc(4'b0100, 20'h000e0, 0); chk(0, 0);
    acc(4'b0010, 20'h000e0, 16'hffff); chkBusy(1);
    waitIdle;
    acc(4'b0010, 20'h00200, 16'h0011);
    rst(0, 1);
    acc(4'b0100, 20'h00200, 0); chk(1, 16'h005a);
    acc(4'b0010, 20'h00200, 16'h0022);
    rst(0, 0);
    acc(4'b0100, 20'h00200, 0); chk(1, 16'h0022);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      sizeStrap <= rxd_size_t'(s);
      acc(4'b1001, bases[s], 0);
      chk(1, 16'hc3a5);
      chkSel(8'h01, 15'h0000);
      acc(4'b1001, bases[s] - 20'h2, 0);
      chk(0, 0);
      chkSel(8'h00, 15'h0000);
      acc(4'b1000, bases[s], 0);
      chk(0, 0);
      chkSel(8'h00, 15'h0000);
      acc(4'b1001, 20'hffffe, 0);
      chk(1, 16'hc3a5);
      chkSel(topSel[s], topPart[s]);
    end
    @(posedge clk);
    sizeStrap <= RXD_SZ_128K;
    stackedStrap <= 1'b1;
    acc(4'b1001, 20'hffffe, 0);
    chk(1, 16'hc3a5);
    chkSel(8'h80, 15'h1fff);
    acc(4'b1001, 20'he0000, 0);
    chkSel(8'h01, 15'h0000);
    print_verdict;
  end
endmodule
